// *** hw/line_status_pkg.sv ***
package line_status_pkg;

  // ==========================================================================
  // register map, byte addresses on the APB
  // ==========================================================================
  localparam logic [31:0] ADDR_DATA = 32'h5000_1100;
  localparam logic [31:0] ADDR_CTRL = 32'h5000_1104;
  localparam logic [31:0] ADDR_LINE_STATUS = 32'h5000_1114;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h5000_1120;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h5000_1124;

  // ==========================================================================
  // line status register fields
  // ==========================================================================
  localparam int LSR_DR_BIT = 0;
  localparam int LSR_OE_BIT = 1;
  localparam int LSR_PE_BIT = 2;
  localparam int LSR_FE_BIT = 3;
  localparam int LSR_BI_BIT = 4;
  localparam int LSR_THRE_BIT = 5;
  localparam int LSR_TEMT_BIT = 6;
  localparam int LSR_RFE_BIT = 7;

  // ==========================================================================
  // control register fields and reset value
  // ==========================================================================
  localparam int CTRL_FIFO_EN_BIT = 0;
  localparam int CTRL_PARITY_EN_BIT = 3;
  localparam int CTRL_THR_LO_BIT = 4;
  localparam int CTRL_IR_EN_BIT = 6;
  localparam int CTRL_PROG_EMPTY_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ==========================================================================
  // interrupt status / mask fields
  // ==========================================================================
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_LINE_BIT = 1;
  localparam int IRQ_THRE_BIT = 2;

  // ==========================================================================
  // fifo geometry, entry layout and thresholds
  // ==========================================================================
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam int ENT_PE_BIT = 8;
  localparam int ENT_FE_BIT = 9;
  localparam int ENT_BI_BIT = 10;
  localparam logic [10:0] BREAK_ENTRY = 11'h700;
  localparam logic [4:0] TX_THR_EMPTY = 5'h00;
  localparam logic [4:0] TX_THR_TWO = 5'h02;
  localparam logic [4:0] TX_THR_QUARTER = 5'h04;
  localparam logic [4:0] TX_THR_HALF = 5'h08;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int CLK_MHZ = 200;
  localparam int BIT_TIME_NS = 80;
  localparam int BIT_CYC = BIT_TIME_NS * CLK_MHZ / 1000;
  localparam logic [3:0] BIT_LAST = 4'(BIT_CYC - 1);
  localparam logic [3:0] BIT_HALF = 4'(BIT_CYC / 2);
  localparam logic [3:0] IR_PULSE_CYC = 4'(BIT_CYC * 3 / 16);
  localparam logic [3:0] CHAR_BITS_BASE = 4'hA;

  typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_WAITHI} rx_state_t;

endpackage : line_status_pkg

// *** hw/line_status_unit.sv ***
`timescale 1ns/10ps

// Overview of operation
// - fifo error flag set by errored entry
// - status read clears it unless later errors
// - transmitter empty when shifter and holding empty
// - holding empty after move into shifter
// - programmable empty mode: flag shows full fifo
// - normal break: low longer than character
// - infrared break: pulses longer than character
// - break yields exactly one all-zero character
// - break travels with character or shows immediately
// - framing error shown at fifo head
// - framing error resyncs on offending low
// - break also sets framing and parity flags
// - parity error only with parity enabled or on break
// - status read clears overrun, parity, framing, break
// - non-fifo overrun overwrites receive buffer
// - fifo overrun keeps fifo, drops new
// - data ready while receive storage holds data
// - infrared enable bit selects break detection
module line_status_unit
  import line_status_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [31:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_SERIAL_IN,
  input wire logic I_IR_IN,
  output logic O_SERIAL_OUT,
  output logic O_IR_OUT,
  output logic O_IRQ
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [7:0] ctrl;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pop_ok;
    logic oe;
    logic pe;
    logic fe;
    logic bi;
    logic rfe;
    logic [15:0][10:0] rx_mem;
    logic [3:0] rx_rd;
    logic [4:0] rx_cnt;
    rx_state_t rx_st;
    logic [3:0] rx_cyc;
    logic [3:0] rx_idx;
    logic [8:0] rx_sh;
    logic rx_mid;
    logic rx_low;
    logic pend;
    logic [10:0] pend_ch;
    logic [7:0] low_cnt;
    logic [3:0] irw;
    logic irlow;
    logic [3:0] ir_run;
    logic [15:0][7:0] tx_mem;
    logic [3:0] tx_rd;
    logic [4:0] tx_cnt;
    logic tx_busy;
    logic [10:0] tx_sh;
    logic [3:0] tx_idx;
    logic [3:0] tx_cyc;
    logic sout;
    logic irout;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic acc, done, capture, mapped;
  logic sel_data, sel_ctrl, sel_lsr, sel_stat, sel_mask;
  logic rd_data, wr_data, rd_lsr, wr_ctrl, wr_stat, wr_mask;
  logic fifo_en, parity_enable, ir, prog, flush;
  logic [4:0] cap, tx_thr;
  logic lo, win_end, lowin, brk_hit, quiet, rlow, bitv;
  logic [3:0] char_bits, last_idx;
  logic [7:0] char_cyc;
  logic push, pop, head_new, stored, err_push, err_other;
  logic oe_set, pe_set, fe_set, bi_set, load, thre_ev;
  logic [10:0] push_ch, ch, head;
  logic [7:0] line_status_register, clr;
  logic [31:0] rd_val;
  logic [3:0] slot;

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    s_nxt = s_r;
    acc = I_PSEL && I_PENABLE;
    done = acc && s_r.pready;
    capture = acc && !s_r.pready;
    sel_data = I_PADDR == ADDR_DATA;
    sel_ctrl = I_PADDR == ADDR_CTRL;
    sel_lsr = I_PADDR == ADDR_LINE_STATUS;
    sel_stat = I_PADDR == ADDR_IRQ_STATUS;
    sel_mask = I_PADDR == ADDR_IRQ_MASK;
    mapped = sel_data || sel_ctrl || sel_lsr || sel_stat || sel_mask;
    rd_data = done && !I_PWRITE && sel_data;
    wr_data = done && I_PWRITE && sel_data;
    rd_lsr = done && !I_PWRITE && sel_lsr;
    wr_ctrl = done && I_PWRITE && sel_ctrl;
    wr_stat = done && I_PWRITE && sel_stat;
    wr_mask = done && I_PWRITE && sel_mask;
    fifo_en = s_r.ctrl[CTRL_FIFO_EN_BIT];
    parity_enable = s_r.ctrl[CTRL_PARITY_EN_BIT];
    ir = s_r.ctrl[CTRL_IR_EN_BIT];
    prog = s_r.ctrl[CTRL_PROG_EMPTY_BIT] && fifo_en;
    cap = fifo_en ? FIFO_DEPTH : 5'h01;
    unique case (s_r.ctrl[CTRL_THR_LO_BIT +: 2])
      2'h0: tx_thr = TX_THR_EMPTY;
      2'h1: tx_thr = TX_THR_TWO;
      2'h2: tx_thr = TX_THR_QUARTER;
      2'h3: tx_thr = TX_THR_HALF;
    endcase

    // status register image, built from the current state
    line_status_register = 8'h00;
    line_status_register[LSR_DR_BIT] = s_r.rx_cnt != 5'h00;
    line_status_register[LSR_OE_BIT] = s_r.oe;
    line_status_register[LSR_PE_BIT] = s_r.pe;
    line_status_register[LSR_FE_BIT] = s_r.fe;
    line_status_register[LSR_BI_BIT] = s_r.bi;
    line_status_register[LSR_THRE_BIT] = prog ? (s_r.tx_cnt == cap) : (s_r.tx_cnt == 5'h00);
    line_status_register[LSR_TEMT_BIT] = (s_r.tx_cnt == 5'h00) && !s_r.tx_busy;
    line_status_register[LSR_RFE_BIT] = s_r.rfe;

    // only flags that were shown to software are cleared by the read
    clr = rd_lsr ? s_r.prdata[7:0] : 8'h00;

    // ========================================================================
    // control register; a fifo mode change flushes both fifos
    // ========================================================================
    flush = wr_ctrl && (I_PWDATA[CTRL_FIFO_EN_BIT] != fifo_en);
    if (wr_ctrl) begin
      s_nxt.ctrl = I_PWDATA[7:0];
    end
    if (flush) begin
      s_nxt.rx_cnt = 5'h00;
      s_nxt.rx_rd = 4'h0;
      s_nxt.tx_cnt = 5'h00;
      s_nxt.tx_rd = 4'h0;
    end

    // ========================================================================
    // break detection
    // ========================================================================
    lo = ir ? !I_IR_IN : !I_SERIAL_IN;
    char_bits = CHAR_BITS_BASE + {3'h0, parity_enable};
    char_cyc = 8'(char_bits * BIT_CYC);
    s_nxt.low_cnt = !lo ? 8'h00 : (s_r.low_cnt == 8'hFF ? s_r.low_cnt : s_r.low_cnt + 8'h01);
    win_end = s_r.irw == BIT_LAST;
    lowin = s_r.irlow || lo;
    s_nxt.irw = win_end ? 4'h0 : s_r.irw + 4'h1;
    s_nxt.irlow = win_end ? 1'b0 : lowin;
    if (win_end) begin
      s_nxt.ir_run = !lowin ? 4'h0 : (s_r.ir_run == 4'hF ? s_r.ir_run : s_r.ir_run + 4'h1);
    end
    brk_hit = (s_r.rx_st != RX_WAITHI) && (ir
      ? (win_end && lowin && s_r.ir_run == char_bits)
      : (lo && s_r.low_cnt == char_cyc));
    quiet = ir ? (s_r.ir_run == 4'h0) : !lo;

    // ========================================================================
    // receiver
    // ========================================================================
    push = 1'b0;
    push_ch = 11'h000;
    ch = 11'h000;
    rlow = s_r.rx_low || lo;
    bitv = 1'b0;
    last_idx = 4'h9 + {3'h0, parity_enable};
    unique case (s_r.rx_st)
      RX_IDLE: begin
        if (lo) begin
          s_nxt.rx_st = RX_FRAME;
          s_nxt.rx_cyc = 4'h1;
          s_nxt.rx_idx = 4'h0;
          s_nxt.rx_low = 1'b1;
        end
      end
      RX_FRAME: begin
        s_nxt.rx_low = rlow;
        s_nxt.rx_cyc = s_r.rx_cyc + 4'h1;
        if (s_r.rx_cyc == BIT_HALF) begin
          s_nxt.rx_mid = !lo;
        end
        if (s_r.rx_cyc == BIT_LAST) begin
          bitv = ir ? !rlow : s_r.rx_mid;
          s_nxt.rx_cyc = 4'h0;
          s_nxt.rx_low = 1'b0;
          s_nxt.rx_idx = s_r.rx_idx + 4'h1;
          if (s_r.rx_idx == 4'h0 && bitv) begin
            s_nxt.rx_st = RX_IDLE;
          end else if (s_r.rx_idx != 4'h0 && s_r.rx_idx < last_idx) begin
            s_nxt.rx_sh[4'(s_r.rx_idx - 4'h1)] = bitv;
          end else if (s_r.rx_idx == last_idx) begin
            ch[7:0] = s_r.rx_sh[7:0];
            ch[ENT_PE_BIT] = parity_enable && (^s_r.rx_sh[7:0] ^ s_r.rx_sh[8]);
            ch[ENT_FE_BIT] = !bitv;
            s_nxt.rx_idx = 4'h1;
            if (bitv) begin
              push = 1'b1;
              push_ch = ch;
              s_nxt.rx_st = RX_IDLE;
            end else if (ch[7:0] == 8'h00) begin
              // a zero character may be the start of a break: hold it back
              s_nxt.pend = 1'b1;
              s_nxt.pend_ch = ch;
            end else begin
              push = 1'b1;
              push_ch = ch;
            end
            // missing stop: stay in frame, the low taken as next start
          end
        end
      end
      RX_WAITHI: begin
        if (quiet) begin
          s_nxt.rx_st = RX_IDLE;
        end
      end
      default: s_nxt.rx_st = RX_IDLE;
    endcase

    if (brk_hit) begin
      push = 1'b1;
      push_ch = BREAK_ENTRY;
      s_nxt.pend = 1'b0;
      s_nxt.rx_st = RX_WAITHI;
    end else if (s_r.pend && quiet) begin
      push = 1'b1;
      push_ch = s_r.pend_ch;
      s_nxt.pend = 1'b0;
    end

    // ========================================================================
    // receive fifo, one entry when fifos are off
    // ========================================================================
    pop = rd_data && s_r.pop_ok && (s_nxt.rx_cnt != 5'h00);
    head_new = 1'b0;
    stored = 1'b0;
    oe_set = 1'b0;
    if (pop) begin
      s_nxt.rx_rd = s_nxt.rx_rd + 4'h1;
      s_nxt.rx_cnt = s_nxt.rx_cnt - 5'h01;
      head_new = s_nxt.rx_cnt != 5'h00;
    end
    if (push) begin
      if (s_nxt.rx_cnt == cap) begin
        oe_set = 1'b1;
        if (!fifo_en) begin
          s_nxt.rx_mem[s_nxt.rx_rd] = push_ch;
          head_new = 1'b1;
          stored = 1'b1;
        end
      end else begin
        slot = 4'(s_nxt.rx_rd + s_nxt.rx_cnt[3:0]);
        s_nxt.rx_mem[slot] = push_ch;
        head_new = head_new || (s_nxt.rx_cnt == 5'h00);
        s_nxt.rx_cnt = s_nxt.rx_cnt + 5'h01;
        stored = 1'b1;
      end
    end
    err_push = stored && fifo_en && (|push_ch[ENT_BI_BIT:ENT_PE_BIT]);
    head = s_nxt.rx_mem[s_nxt.rx_rd];
    // head entry flags surface when it reaches the head
    pe_set = head_new && head[ENT_PE_BIT];
    fe_set = head_new && head[ENT_FE_BIT];
    bi_set = head_new && head[ENT_BI_BIT];
    err_other = 1'b0;
    for (int i = 1; i < 16; i++) begin
      if (5'(i) < s_nxt.rx_cnt) begin
        err_other = err_other || (|s_nxt.rx_mem[4'(s_nxt.rx_rd + 4'(i))][ENT_BI_BIT:ENT_PE_BIT]);
      end
    end

    // set wins over the read clear
    s_nxt.oe = (s_r.oe && !clr[LSR_OE_BIT]) || oe_set;
    s_nxt.pe = (s_r.pe && !clr[LSR_PE_BIT]) || pe_set;
    s_nxt.fe = (s_r.fe && !clr[LSR_FE_BIT]) || fe_set;
    s_nxt.bi = (s_r.bi && !clr[LSR_BI_BIT]) || bi_set;
    s_nxt.rfe = fifo_en && ((s_r.rfe && !(clr[LSR_RFE_BIT] && !err_other)) || err_push);

    // ========================================================================
    // transmitter
    // ========================================================================
    load = !s_r.tx_busy && (s_r.tx_cnt != 5'h00) && !flush;
    if (s_r.tx_busy) begin
      s_nxt.tx_cyc = s_r.tx_cyc + 4'h1;
      if (s_r.tx_cyc == BIT_LAST) begin
        s_nxt.tx_cyc = 4'h0;
        s_nxt.tx_sh = {1'b1, s_r.tx_sh[10:1]};
        s_nxt.tx_idx = s_r.tx_idx + 4'h1;
        s_nxt.tx_busy = s_r.tx_idx != last_idx;
      end
    end
    if (load) begin
      s_nxt.tx_sh = parity_enable ? {1'b1, ^s_r.tx_mem[s_r.tx_rd], s_r.tx_mem[s_r.tx_rd], 1'b0}
                        : {2'h3, s_r.tx_mem[s_r.tx_rd], 1'b0};
      s_nxt.tx_busy = 1'b1;
      s_nxt.tx_cyc = 4'h0;
      s_nxt.tx_idx = 4'h0;
      s_nxt.tx_rd = s_r.tx_rd + 4'h1;
      s_nxt.tx_cnt = s_r.tx_cnt - 5'h01;
    end
    if (wr_data && s_nxt.tx_cnt != cap) begin
      s_nxt.tx_mem[4'(s_nxt.tx_rd + s_nxt.tx_cnt[3:0])] = I_PWDATA[7:0];
      s_nxt.tx_cnt = s_nxt.tx_cnt + 5'h01;
    end
    thre_ev = prog ? (s_r.tx_cnt > tx_thr && s_nxt.tx_cnt <= tx_thr)
                   : (load && s_nxt.tx_cnt == 5'h00);
    s_nxt.sout = s_nxt.tx_busy ? s_nxt.tx_sh[0] : 1'b1;
    s_nxt.irout = s_nxt.tx_busy && !s_nxt.tx_sh[0] && (s_nxt.tx_cyc < IR_PULSE_CYC);

    // ========================================================================
    // interrupts
    // ========================================================================
    s_nxt.irq_stat = s_r.irq_stat & ~(wr_stat ? I_PWDATA[2:0] : 3'h0);
    s_nxt.irq_stat[IRQ_RX_BIT] = s_nxt.irq_stat[IRQ_RX_BIT] || stored;
    s_nxt.irq_stat[IRQ_LINE_BIT] = s_nxt.irq_stat[IRQ_LINE_BIT] ||
                                   oe_set || pe_set || fe_set || bi_set;
    s_nxt.irq_stat[IRQ_THRE_BIT] = s_nxt.irq_stat[IRQ_THRE_BIT] || thre_ev;
    if (wr_mask) begin
      s_nxt.irq_mask = I_PWDATA[2:0];
    end
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);

    // ========================================================================
    // apb answer: one wait state, read data captured in the first access cycle
    // ========================================================================
    rd_val = 32'h0000_0000;
    if (sel_data) begin
      rd_val[7:0] = s_r.rx_mem[s_r.rx_rd][7:0] & {8{s_r.rx_cnt != 5'h00}};
    end
    if (sel_ctrl) begin
      rd_val[7:0] = s_r.ctrl;
    end
    if (sel_lsr) begin
      rd_val[7:0] = line_status_register;
    end
    if (sel_stat) begin
      rd_val[2:0] = s_r.irq_stat;
    end
    if (sel_mask) begin
      rd_val[2:0] = s_r.irq_mask;
    end
    s_nxt.pready = capture;
    s_nxt.pslverr = capture && !mapped;
    if (capture) begin
      s_nxt.prdata = I_PWRITE ? 32'h0000_0000 : rd_val;
      s_nxt.pop_ok = sel_data && (s_r.rx_cnt != 5'h00);
    end

    if (I_RESET) begin
      s_nxt = '0;
      s_nxt.ctrl = CTRL_RESET;
      s_nxt.sout = 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    s_r <= s_nxt;
  end

  assign O_PRDATA = s_r.prdata;
  assign O_PREADY = s_r.pready;
  assign O_PSLVERR = s_r.pslverr;
  assign O_SERIAL_OUT = s_r.sout;
  assign O_IR_OUT = s_r.irout;
  assign O_IRQ = s_r.irq;

endmodule : line_status_unit

// *** tb/line_status_asserts.sv ***
`timescale 1ns/10ps
// ==================================================================
// port-level checks of the line status unit
// ==================================================================
module line_status_asserts
  import line_status_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [31:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic I_SERIAL_IN,
  input wire logic I_IR_IN,
  input wire logic O_SERIAL_OUT,
  input wire logic O_IR_OUT,
  input wire logic O_IRQ
);
  logic done, lsr_rd, mapped;
  logic [7:0] ctrl_r, mask_r;
  assign done = I_PSEL && I_PENABLE && O_PREADY;
  assign lsr_rd = done && !I_PWRITE && I_PADDR == ADDR_LINE_STATUS;
  assign mapped = I_PADDR == ADDR_DATA || I_PADDR == ADDR_CTRL ||
    I_PADDR == ADDR_LINE_STATUS || I_PADDR == ADDR_IRQ_STATUS || I_PADDR == ADDR_IRQ_MASK;
  // shadow copies of the settings that change what the status and the interrupt line may show
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      ctrl_r <= CTRL_RESET;
      mask_r <= 8'h00;
    end else if (done && I_PWRITE && I_PADDR == ADDR_CTRL) begin
      ctrl_r <= I_PWDATA[7:0];
    end else if (done && I_PWRITE && I_PADDR == ADDR_IRQ_MASK) begin
      mask_r <= I_PWDATA[7:0];
    end
  end
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);
  sequence setup_then_access;
    I_PSEL && !I_PENABLE ##1 I_PSEL && I_PENABLE;
  endsequence
  sequence one_wait_answer;
    !O_PREADY ##1 O_PREADY;
  endsequence
  sequence mask_clear;
    (mask_r == 8'h00) [*2];
  endsequence
  a_ready_wait: assert property (setup_then_access |-> one_wait_answer)
    else $error("ready not after one wait cycle");
  a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  a_err_map: assert property (done |-> O_PSLVERR == !mapped && (mapped || O_PRDATA == 32'h0))
    else $error("slave error does not match address map");
  a_err_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("slave error without ready");
  a_break_flags: assert property (lsr_rd && O_PRDATA[LSR_BI_BIT]
    |-> O_PRDATA[LSR_FE_BIT] && O_PRDATA[LSR_PE_BIT])
    else $error("break without framing and parity flags");
  a_temt_thre: assert property (lsr_rd && !ctrl_r[CTRL_PROG_EMPTY_BIT]
    && O_PRDATA[LSR_TEMT_BIT] |-> O_PRDATA[LSR_THRE_BIT])
    else $error("transmitter empty but holding not empty");
  a_rfe_fifo: assert property (lsr_rd && !ctrl_r[CTRL_FIFO_EN_BIT]
    |-> !O_PRDATA[LSR_RFE_BIT])
    else $error("fifo error flag without fifo");
  a_irq_masked: assert property (mask_clear |-> !O_IRQ)
    else $error("interrupt while all masked");
  a_reset_lines: assert property (disable iff (1'b0) I_RESET
    |=> O_SERIAL_OUT && !O_IR_OUT && !O_IRQ && !O_PREADY)
    else $error("outputs not idle after reset");
endmodule : line_status_asserts

bind line_status_unit line_status_asserts u_chk (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .I_SERIAL_IN(I_SERIAL_IN), .I_IR_IN(I_IR_IN), .O_SERIAL_OUT(O_SERIAL_OUT),
  .O_IR_OUT(O_IR_OUT), .O_IRQ(O_IRQ));

// *** tb/serial_source.sv ***
`timescale 1ns/10ps
// ==================================================================
// remote transmitter on the receive lines, idle high
// ==================================================================
module serial_source
  import line_status_pkg::*;
(
  input wire logic clk,
  output logic ser,
  output logic ir
);
  initial begin
    ser = 1'b1;
    ir = 1'b1;
  end
  // one bit time; in infrared mode a zero is a short low pulse
  task automatic bit_out(input logic b, input logic irm);
    for (int i = 0; i < BIT_CYC; i++) begin
      @(posedge clk);
      ser <= irm | b;
      ir <= !(irm && !b && i < int'(IR_PULSE_CYC));
    end
  endtask : bit_out
  // no_stop leaves out the stop bit so the next start takes its place
  task automatic send(input logic [7:0] d, input logic parity_enable, bad_par, no_stop, irm);
    bit_out(1'b0, irm);
    for (int k = 0; k < 8; k++) bit_out(d[k], irm);
    if (parity_enable) bit_out((^d) ^ bad_par, irm);
    if (!no_stop) bit_out(1'b1, irm);
  endtask : send
  // low for twelve bit times, then two idle bits
  task automatic brk(input logic irm);
    for (int k = 0; k < 14; k++) bit_out(k > 11, irm);
  endtask : brk
endmodule : serial_source

// *** tb/tb.sv ***
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("mismatch at %0t: got %h exp %h", $time, got, exp); \
    end \
  end
// ==================================================================
// bench for the line status unit
// ==================================================================
module tb
  import line_status_pkg::*;
;
  logic clk, rst, psel, penable, pwrite, ser, ir, err;
  logic [31:0] paddr, pwdata, prdata, q;
  logic pready, pslverr, sout, irout, irq;
  int num_errors, n_compared;
  line_status_unit dut (.I_CLOCK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SERIAL_IN(ser), .I_IR_IN(ir),
    .O_SERIAL_OUT(sout), .O_IR_OUT(irout), .O_IRQ(irq));
  serial_source src (.clk(clk), .ser(ser), .ir(ir));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic chk_rd(input logic [31:0] a, e);
    apb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask : chk_rd
  task automatic wait_temt;
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_LINE_STATUS, 32'h0);
      n++;
    end while (q[LSR_TEMT_BIT] !== 1'b1 && n < 1000);
    if (n >= 1000) num_errors++;
  endtask : wait_temt
  // follows one transmitted frame on both lines, sampling near each bit centre
  task automatic chk_line(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    while (sout !== 1'b0) @(posedge clk);
    `CHK(irout, 1'b1)
    repeat (7) @(posedge clk);
    for (int k = 0; k < 10; k++) begin
      `CHK(sout, f[k])
      `CHK(irout, 1'b0)
      repeat (16) @(posedge clk);
    end
  endtask : chk_line
  task automatic t_reset;
    chk_rd(ADDR_LINE_STATUS, 32'h60);
    chk_rd(ADDR_CTRL, {24'h0, CTRL_RESET});
    wr(ADDR_LINE_STATUS, 32'hFF);
    chk_rd(ADDR_LINE_STATUS, 32'h60);
    chk_rd(32'h5000_1108, 32'h0);
    `CHK(err, 1'b1)
  endtask : t_reset
  task automatic t_nonfifo;
    wr(ADDR_CTRL, 32'h08);
    src.send(8'hA5, 1'b1, 1'b0, 1'b0, 1'b0);
    chk_rd(ADDR_LINE_STATUS, 32'h61);
    src.send(8'h3C, 1'b1, 1'b1, 1'b0, 1'b0);
    chk_rd(ADDR_LINE_STATUS, 32'h67);
    chk_rd(ADDR_DATA, 32'h3C);
    chk_rd(ADDR_LINE_STATUS, 32'h60);
    wr(ADDR_CTRL, 32'h00);
    src.send(8'h3C, 1'b1, 1'b1, 1'b0, 1'b0);
    chk_rd(ADDR_LINE_STATUS, 32'h61);
    chk_rd(ADDR_DATA, 32'h3C);
  endtask : t_nonfifo
  task automatic t_fifo_err;
    wr(ADDR_CTRL, 32'h09);
    src.send(8'h11, 1'b1, 1'b0, 1'b0, 1'b0);
    src.send(8'h22, 1'b1, 1'b0, 1'b1, 1'b0);
    src.send(8'h33, 1'b1, 1'b0, 1'b0, 1'b0);
    chk_rd(ADDR_LINE_STATUS, 32'hE1);
    chk_rd(ADDR_DATA, 32'h11);
    chk_rd(ADDR_LINE_STATUS, 32'hE9);
    chk_rd(ADDR_LINE_STATUS, 32'h61);
    chk_rd(ADDR_DATA, 32'h22);
    chk_rd(ADDR_DATA, 32'h33);
    chk_rd(ADDR_LINE_STATUS, 32'h60);
  endtask : t_fifo_err
  task automatic t_overrun;
    wr(ADDR_CTRL, 32'h01);
    for (int i = 0; i < 17; i++) src.send(8'h40 + 8'(i), 1'b0, 1'b0, 1'b0, 1'b0);
    chk_rd(ADDR_LINE_STATUS, 32'h63);
    for (int i = 0; i < 16; i++) chk_rd(ADDR_DATA, {24'h0, 8'h40 + 8'(i)});
    chk_rd(ADDR_LINE_STATUS, 32'h60);
  endtask : t_overrun
  task automatic t_break;
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_CTRL, m == 0 ? 32'h01 : m == 1 ? 32'h41 : 32'h00);
      src.brk(m == 1);
      chk_rd(ADDR_LINE_STATUS, m == 2 ? 32'h7D : 32'hFD);
      chk_rd(ADDR_DATA, 32'h0);
      chk_rd(ADDR_LINE_STATUS, 32'h60);
    end
  endtask : t_break
  task automatic t_tx;
    wr(ADDR_CTRL, 32'h00);
    wr(ADDR_IRQ_STATUS, 32'h7);
    wr(ADDR_IRQ_MASK, 32'h4);
    `CHK(irq, 1'b0)
    wr(ADDR_DATA, 32'h55);
    chk_rd(ADDR_LINE_STATUS, 32'h20);
    `CHK(irq, 1'b1)
    wait_temt;
    chk_rd(ADDR_LINE_STATUS, 32'h60);
    wr(ADDR_DATA, 32'hA3);
    chk_line(8'hA3);
    wr(ADDR_IRQ_STATUS, 32'h4);
    chk_rd(ADDR_IRQ_STATUS, 32'h0);
    `CHK(irq, 1'b0)
    wr(ADDR_CTRL, 32'h81);
    chk_rd(ADDR_LINE_STATUS, 32'h40);
    for (int i = 0; i < 17; i++) wr(ADDR_DATA, 32'(i));
    chk_rd(ADDR_LINE_STATUS, 32'h20);
    wait_temt;
    chk_rd(ADDR_LINE_STATUS, 32'h40);
  endtask : t_tx
  task automatic test_done;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_nonfifo;
    t_fifo_err;
    t_overrun;
    t_break;
    t_tx;
    test_done;
  end
  initial begin
    #200000;
    num_errors++;
    test_done;
  end
endmodule : tb
